/* File: rtl/ars_pkg.sv */
// Package for the accumulator round, write saturation and barrel shifter block.
// Assumes one core clock; all users import the whole package.
package ars_pkg;

    localparam int ARS_ACC_W  = 40;
    localparam int ARS_WORD_W = 16;
    localparam int ARS_AMT_W  = 6;

    // Accumulator bit positions
    localparam int ARS_RND_BIT  = 15;
    localparam int ARS_HI_LSB   = 16;
    localparam int ARS_HI_MSB   = 31;
    localparam int ARS_SIGN_BIT = 39;

    // Saturation limits, rounding, write-back pointer and shifter constants
    localparam logic [15:0] ARS_SAT_POS   = 16'h7FFF;
    localparam logic [15:0] ARS_SAT_NEG   = 16'h8000;
    localparam logic [15:0] ARS_LSW_HALF  = 16'h8000;
    localparam logic [23:0] ARS_ONE_24    = 24'h00_0001;
    localparam logic [15:0] ARS_PTR_STEP  = 16'h0002;
    localparam logic [15:0] ARS_PTR_RST   = 16'h0000;
    localparam logic [5:0]  ARS_AMT_ONE   = 6'h01;
    localparam logic [5:0]  ARS_AMT_ZERO  = 6'h00;
    localparam logic [5:0]  ARS_SHIFT_MAX = 6'h10;
    localparam logic [7:0]  ARS_X_EXT_0   = 8'h00;
    localparam logic [15:0] ARS_X_PAD_0   = 16'h0000;
    localparam logic [23:0] ARS_X_PAD_L   = 24'h00_0000;

    // Round mode encoding: one means conventional (biased)
    localparam logic ARS_RND_CONV = 1'b1;

    typedef logic [ARS_ACC_W-1:0]  ars_acc_t;
    typedef logic [ARS_WORD_W-1:0] ars_word_t;

    typedef enum logic [2:0] {
        ARS_OP_TRUNC = 3'b001,
        ARS_OP_ROUND = 3'b010,
        ARS_OP_MACWB = 3'b100
    } ars_store_op_t;

    typedef enum logic [2:0] {
        ARS_SRC_A = 3'b001,
        ARS_SRC_B = 3'b010,
        ARS_SRC_X = 3'b100
    } ars_src_t;

    typedef struct packed {
        logic round_mode_select;
        logic write_saturate_enable;
    } ars_ctrl_t;

    localparam ars_ctrl_t ARS_CTRL_RST = '{round_mode_select: 1'b0, write_saturate_enable: 1'b0};

    typedef struct packed {
        logic          valid;
        ars_store_op_t op;
        logic          acc_sel;
        logic          indirect;
        ars_word_t     addr;
    } ars_store_req_t;

    typedef struct packed {
        logic            valid;
        ars_src_t        src;
        logic            arith;
        logic [5:0]      amount;
        ars_word_t       xdata;
    } ars_shift_req_t;

    typedef struct packed {
        logic      valid;
        ars_word_t addr;
        ars_word_t data;
    } ars_xwr_t;

    typedef struct packed {
        logic      valid;
        ars_acc_t  acc;
        ars_word_t word;
    } ars_shift_res_t;

endpackage : ars_pkg

/* File: rtl/ars_round_sat.sv */
// Combinational round and data-space write saturation of one accumulator.
// Assumes the caller registers the result; no state inside.
`timescale 1ns/1ps
`default_nettype none

module ars_round_sat
    import ars_pkg::*;
(
    input  wire logic      i_acc_sign_unused_n,
    input  wire ars_acc_t  i_acc,
    input  wire logic      i_round_en,
    input  wire logic      i_convergent,
    input  wire logic      i_sat_en,
    output var  ars_word_t o_word
);

    logic        inc;
    logic [23:0] sum;
    logic        ovf_pos;
    logic        ovf_neg;

    always_comb
    begin
        inc = 1'b0;
        if (i_round_en)
        begin
            inc = i_acc[ARS_RND_BIT];                                         // [RULE_04]
            if (i_convergent && (i_acc[ARS_RND_BIT:0] == ARS_LSW_HALF))
            begin
                inc = i_acc[ARS_HI_LSB];                                      // [RULE_05]
            end
        end
    end

    // 24-bit sum keeps the round adder carry visible to saturation
    assign sum = i_acc[ARS_SIGN_BIT:ARS_HI_LSB] + (inc ? ARS_ONE_24 : '0);   // [RULE_02] [RULE_03]

    assign ovf_pos = !i_acc[ARS_SIGN_BIT] && (sum[23:ARS_RND_BIT] != '0);     // [RULE_09] [RULE_12]
    assign ovf_neg = i_acc[ARS_SIGN_BIT] && (sum[23:ARS_RND_BIT] != '1);      // [RULE_09] [RULE_12]

    always_comb
    begin
        o_word = sum[ARS_RND_BIT:0];                                          // [RULE_13]
        if (i_sat_en && ovf_pos)
        begin
            o_word = ARS_SAT_POS;                                             // [RULE_10]
        end
        else if (i_sat_en && ovf_neg)
        begin
            o_word = ARS_SAT_NEG;                                             // [RULE_11]
        end
    end

endmodule : ars_round_sat

`default_nettype wire

/* File: rtl/ars_store_shift.sv */
// Accumulator store path (round, write saturation) and 40-bit barrel shifter.
// Assumes accumulators and requests come from core control, synchronous to i_clk.
//
// Operation
// [RULE_01] Control bit picks conventional or convergent rounding for stores.
// [RULE_02] Rounding yields a 16-bit 1.15 word for saturation, combinationally.
// [RULE_03] Without rounding, store high word truncated; low word discarded.
// [RULE_04] Conventional: add accumulator bit 15 to the high word.
// [RULE_05] Convergent: low word exactly 0x8000 increments only if bit 16 set.
// [RULE_06] Truncated and rounded stores write memory over X bus after saturation.
// [RULE_07] Multiply-accumulate write-back is always rounded, through X write bus; direct write-back only loads the pointer register.
// [RULE_08] Write saturation changes only the written word, never the accumulator.
// [RULE_09] Saturation uses round word plus accumulator and round-adder overflow.
// [RULE_10] Saturation on: values above 0x007FFF written as 0x7FFF.
// [RULE_11] Saturation on: values below 0xFF8000 written as 0x8000.
// [RULE_12] Sign of the tested value comes from accumulator bit 39.
// [RULE_13] Saturation off: word passes to memory unmodified.
// [RULE_14] Shifter does right (arith/logic) or left shifts up to 16, one cycle.
// [RULE_15] Shifter operand is accumulator A, B or X data bus.
// [RULE_16] Signed amount: positive right, negative left, zero unchanged.
// [RULE_17] Shifter is 40 bits wide; 40-bit and 16-bit results.
// [RULE_18] X data enters at bits 16..31 for right, 0..15 for left.
// [RULE_19] Write-back goes to pointer register or its target, then pointer plus 2.
// [RULE_20] Core keeps shift amounts within plus or minus 16.
`timescale 1ns/1ps
`default_nettype none

module ars_store_shift
    import ars_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    input  wire ars_acc_t       i_acc_a,
    input  wire ars_acc_t       i_acc_b,
    input  wire logic           i_ctrl_wr,
    input  wire ars_ctrl_t      i_ctrl,
    input  wire logic           i_wbptr_wr,
    input  wire ars_word_t      i_wbptr_data,
    input  wire ars_store_req_t i_store,
    input  wire ars_shift_req_t i_shift,
    output var  ars_ctrl_t      o_ctrl,
    output var  ars_word_t      o_wbptr,
    output var  ars_xwr_t       o_xwr,
    output var  ars_shift_res_t o_shift
);

    ars_ctrl_t      core_control_reg;
    ars_word_t      writeback_pointer_reg;
    ars_word_t      writeback_pointer_next;
    ars_xwr_t       xwr_reg;
    ars_xwr_t       xwr_next;
    ars_shift_res_t shift_reg;
    ars_shift_res_t shift_next;

    ars_acc_t       src_acc;
    logic           round_en;
    logic           convergent;
    ars_word_t      store_word;

    ars_acc_t       shift_op;
    ars_acc_t       shift_res;
    logic           shift_left;
    logic [5:0]     shift_mag;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            core_control_reg <= ARS_CTRL_RST;
        end
        else if (i_ctrl_wr)
        begin
            core_control_reg <= i_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Store path
    // ------------------------------------------------------------
    // Accumulators are only read here, so saturation never reaches them
    assign src_acc = i_store.acc_sel ? i_acc_b : i_acc_a;                      // [RULE_08]

    always_comb
    begin
        round_en = 1'b0;
        case (i_store.op)
            ARS_OP_ROUND: round_en = 1'b1;                                    // [RULE_06]
            ARS_OP_MACWB: round_en = 1'b1;                                    // [RULE_07]
            default:      round_en = 1'b0;                                    // [RULE_03]
        endcase
    end

    assign convergent = (core_control_reg.round_mode_select != ARS_RND_CONV); // [RULE_01]

    ars_round_sat u_round_sat
    (
        .i_acc_sign_unused_n (1'b1),
        .i_acc               (src_acc),
        .i_round_en          (round_en),
        .i_convergent        (convergent),
        .i_sat_en            (core_control_reg.write_saturate_enable),
        .o_word              (store_word)
    );

    // Write-back update beats a same-cycle core load of the pointer
    always_comb
    begin
        xwr_next               = '0;
        writeback_pointer_next = writeback_pointer_reg;
        if (i_wbptr_wr)
        begin
            writeback_pointer_next = i_wbptr_data;
        end
        if (i_store.valid)
        begin
            case (i_store.op)
                ARS_OP_TRUNC, ARS_OP_ROUND:
                begin
                    xwr_next.valid = 1'b1;                                    // [RULE_06]
                    xwr_next.addr  = i_store.addr;
                    xwr_next.data  = store_word;
                end
                ARS_OP_MACWB:
                begin
                    if (i_store.indirect)
                    begin
                        xwr_next.valid         = 1'b1;                        // [RULE_07]
                        xwr_next.addr          = writeback_pointer_reg;       // [RULE_19]
                        xwr_next.data          = store_word;
                        writeback_pointer_next = writeback_pointer_reg + ARS_PTR_STEP; // [RULE_19]
                    end
                    else
                    begin
                        writeback_pointer_next = store_word;                  // [RULE_19]
                    end
                end
                default:
                begin
                    xwr_next.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            xwr_reg <= '0;
        end
        else
        begin
            xwr_reg <= xwr_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            writeback_pointer_reg <= ARS_PTR_RST;
        end
        else
        begin
            writeback_pointer_reg <= writeback_pointer_next;
        end
    end

    // ------------------------------------------------------------
    // Barrel shifter
    // ------------------------------------------------------------
    assign shift_left = i_shift.amount[ARS_AMT_W-1];                          // [RULE_16]
    // Magnitudes past 16 are not trimmed; core keeps them in range
    assign shift_mag  = shift_left ? 6'(~i_shift.amount + ARS_AMT_ONE)
                                   : i_shift.amount;                          // [RULE_20]

    always_comb
    begin
        shift_op = i_acc_a;
        case (i_shift.src)
            ARS_SRC_A: shift_op = i_acc_a;                                    // [RULE_15]
            ARS_SRC_B: shift_op = i_acc_b;                                    // [RULE_15]
            ARS_SRC_X:
            begin
                if (shift_left)
                begin
                    shift_op = {ARS_X_PAD_L, i_shift.xdata};                  // [RULE_18]
                end
                else if (i_shift.arith)
                begin
                    shift_op = {{8{i_shift.xdata[ARS_WORD_W-1]}}, i_shift.xdata, ARS_X_PAD_0}; // [RULE_18]
                end
                else
                begin
                    shift_op = {ARS_X_EXT_0, i_shift.xdata, ARS_X_PAD_0};     // [RULE_18]
                end
            end
            default: shift_op = i_acc_a;
        endcase
    end

    always_comb
    begin
        if (shift_left)
        begin
            shift_res = shift_op << shift_mag;                                // [RULE_14]
        end
        else if (i_shift.arith)
        begin
            shift_res = ARS_ACC_W'($signed(shift_op) >>> shift_mag);          // [RULE_14]
        end
        else
        begin
            shift_res = shift_op >> shift_mag;                                // [RULE_14]
        end
    end

    always_comb
    begin
        shift_next       = '0;
        shift_next.valid = i_shift.valid;
        shift_next.acc   = shift_res;                                         // [RULE_17]
        if (shift_left)
        begin
            shift_next.word = shift_res[ARS_WORD_W-1:0];                      // [RULE_17]
        end
        else
        begin
            shift_next.word = shift_res[ARS_HI_MSB:ARS_HI_LSB];               // [RULE_17]
        end
    end

    // Result registered: one cycle per shift
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            shift_reg <= '0;
        end
        else
        begin
            shift_reg <= shift_next;                                          // [RULE_14]
        end
    end

    assign o_ctrl  = core_control_reg;
    assign o_wbptr = writeback_pointer_reg;
    assign o_xwr   = xwr_reg;
    assign o_shift = shift_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    logic      st_go;
    logic      sat_on;
    logic      conv_mode;
    logic      hi_ovf_pos;
    logic      hi_ovf_neg;
    ars_word_t hi_word;

    assign st_go      = i_store.valid;
    assign sat_on     = core_control_reg.write_saturate_enable;
    assign conv_mode  = core_control_reg.round_mode_select == ARS_RND_CONV;
    assign hi_word    = src_acc[ARS_HI_MSB:ARS_HI_LSB];
    assign hi_ovf_pos = !src_acc[ARS_SIGN_BIT] && (src_acc[ARS_SIGN_BIT:ARS_HI_MSB] != '0);
    assign hi_ovf_neg = src_acc[ARS_SIGN_BIT] && (src_acc[ARS_SIGN_BIT:ARS_HI_MSB] != '1);

    a_trunc_store: assert property (                                          // [RULE_03]
        st_go && i_store.op == ARS_OP_TRUNC && !sat_on && !i_ctrl_wr
        |=> o_xwr.valid && o_xwr.data == $past(hi_word) && o_xwr.addr == $past(i_store.addr))
        else $error("truncated store word wrong");

    a_conv_round: assert property (                                           // [RULE_04]
        st_go && i_store.op == ARS_OP_ROUND && conv_mode && !sat_on && !hi_ovf_pos && !hi_ovf_neg
        |=> o_xwr.data == 16'($past(hi_word) + $past(src_acc[ARS_RND_BIT])))
        else $error("conventional round wrong");

    a_conv_even: assert property (                                            // [RULE_05]
        st_go && i_store.op == ARS_OP_ROUND && !conv_mode && !sat_on && !hi_ovf_pos
        && src_acc[ARS_RND_BIT:0] == ARS_LSW_HALF && !src_acc[ARS_HI_LSB]
        |=> o_xwr.valid && o_xwr.data == $past(hi_word))
        else $error("convergent tie not held");

    a_sat_high: assert property (                                             // [RULE_10]
        st_go && !i_store.indirect && i_store.op != ARS_OP_MACWB && sat_on && hi_ovf_pos
        |=> o_xwr.valid && o_xwr.data == ARS_SAT_POS)
        else $error("positive saturation missing");

    a_sat_low: assert property (                                              // [RULE_11]
        st_go && i_store.op == ARS_OP_TRUNC && sat_on && hi_ovf_neg
        |=> o_xwr.data == ARS_SAT_NEG)
        else $error("negative saturation missing");

    a_sat_bypass: assert property (                                           // [RULE_13]
        st_go && i_store.op == ARS_OP_TRUNC && !sat_on && (hi_ovf_pos || hi_ovf_neg)
        |=> o_xwr.data == $past(hi_word))
        else $error("unsaturated word modified");

    a_wb_indirect: assert property (                                          // [RULE_19]
        st_go && i_store.op == ARS_OP_MACWB && i_store.indirect
        |=> o_xwr.valid && o_xwr.addr == $past(writeback_pointer_reg)
            && o_wbptr == 16'($past(writeback_pointer_reg) + ARS_PTR_STEP))
        else $error("indirect write-back pointer wrong");

    a_wb_direct: assert property (                                            // [RULE_07]
        st_go && i_store.op == ARS_OP_MACWB && !i_store.indirect && !sat_on && conv_mode
        && !hi_ovf_pos && !hi_ovf_neg
        |=> !o_xwr.valid && o_wbptr == 16'($past(hi_word) + $past(src_acc[ARS_RND_BIT])))
        else $error("direct write-back not rounded");

    a_shift_zero: assert property (                                           // [RULE_16]
        i_shift.valid && i_shift.amount == ARS_AMT_ZERO && i_shift.src == ARS_SRC_B
        |=> o_shift.valid && o_shift.acc == $past(i_acc_b))
        else $error("zero shift changed operand");

    a_shift_right: assert property (                                          // [RULE_14]
        i_shift.valid && i_shift.src == ARS_SRC_X && !i_shift.arith
        && !shift_left && i_shift.amount <= ARS_SHIFT_MAX
        |=> o_shift.word == 16'($past(i_shift.xdata) >> $past(i_shift.amount)))
        else $error("logical right shift of X wrong");

    c_sat_pos: cover property (st_go && sat_on && hi_ovf_pos ##1 o_xwr.data == ARS_SAT_POS);
    c_wb_ind:  cover property (st_go && i_store.op == ARS_OP_MACWB && i_store.indirect);
    c_shl_x:   cover property (i_shift.valid && shift_left && i_shift.src == ARS_SRC_X);

endmodule : ars_store_shift

`default_nettype wire

/* File: tb/ars_dmem_model.sv */
// Data space write side: records the last word taken from the X write bus.
// Assumes the block's X write bus, sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none

module ars_dmem_model
    import ars_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rstn,
    input  wire ars_xwr_t i_xwr,
    output var  ars_xwr_t o_last
);
    // Word-wide sink; byte lanes are not modelled
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_last <= '0;
        else if (i_xwr.valid)
            o_last <= i_xwr;
    end
endmodule : ars_dmem_model

`default_nettype wire

/* File: tb/ars_store_shift_test.sv */
// Self-checking bench for the store path and the barrel shifter.
// Assumes the design package and the data space model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module ars_store_shift_test
    import ars_pkg::*;
;
    logic           clk;
    logic           rstn;
    ars_acc_t       acc_a;
    ars_acc_t       acc_b;
    logic           ctrl_wr;
    ars_ctrl_t      ctrl;
    logic           wbptr_wr;
    ars_word_t      wbptr_data;
    ars_store_req_t store;
    ars_shift_req_t shift;
    ars_ctrl_t      ctrl_q;
    ars_word_t      wbptr;
    ars_xwr_t       xwr;
    ars_shift_res_t shres;
    ars_xwr_t       mem_last;
    int             errors;
    int             tests_run;

    ars_store_shift u_ars_store_shift (
        .i_clk        (clk),
        .i_rstn       (rstn),
        .i_acc_a      (acc_a),
        .i_acc_b      (acc_b),
        .i_ctrl_wr    (ctrl_wr),
        .i_ctrl       (ctrl),
        .i_wbptr_wr   (wbptr_wr),
        .i_wbptr_data (wbptr_data),
        .i_store      (store),
        .i_shift      (shift),
        .o_ctrl       (ctrl_q),
        .o_wbptr      (wbptr),
        .o_xwr        (xwr),
        .o_shift      (shres)
    );

    ars_dmem_model u_ars_dmem_model (
        .i_clk  (clk),
        .i_rstn (rstn),
        .i_xwr  (xwr),
        .o_last (mem_last)
    );

    always #4 clk = ~clk;

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input ars_word_t got, input ars_word_t exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_acc(input ars_acc_t got, input ars_acc_t exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_acc

    // Reference round and saturation; guard bits kept so overflow is seen
    function automatic ars_word_t exp_store(input ars_acc_t a, input logic rnd, input ars_ctrl_t c);
        logic        inc;
        logic [24:0] s;
        inc = rnd && a[15] && !(c.round_mode_select != ARS_RND_CONV && a[15:0] == 16'h8000 && !a[16]);
        s   = {a[39], a[39:16]} + {24'h00_0000, inc};
        if (c.write_saturate_enable && $signed(s) > $signed(25'h000_7FFF)) return 16'h7FFF;
        if (c.write_saturate_enable && $signed(s) < $signed(25'h1FF_8000)) return 16'h8000;
        return s[15:0];
    endfunction : exp_store

    function automatic ars_acc_t exp_shift(input ars_shift_req_t r, input ars_acc_t a, input ars_acc_t b);
        ars_acc_t op;
        int       n;
        n = int'($signed(r.amount));
        if (r.src == ARS_SRC_A) op = a;
        else if (r.src == ARS_SRC_B) op = b;
        else if (n >= 0) op = {(r.arith ? {8{r.xdata[15]}} : 8'h00), r.xdata, 16'h0000};
        else op = {24'h00_0000, r.xdata};
        if (n < 0) return op << (-n);
        if (r.arith) return $signed(op) >>> n;
        return op >> n;
    endfunction : exp_shift

    task automatic set_ctrl(input logic conv, input logic sat);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl    <= '{round_mode_select: conv, write_saturate_enable: sat};
        @(posedge clk);
        ctrl_wr <= 1'b0;
        #1;
        cmp_bit(ctrl_q.round_mode_select, conv, "ctrl mode");
        cmp_bit(ctrl_q.write_saturate_enable, sat, "ctrl sat");
    endtask : set_ctrl

    // Other accumulator carries the inverse so a wrong select shows
    task automatic run_store(input ars_store_op_t op, input logic sel, input logic ind, input ars_word_t addr,
                             input ars_acc_t a);
        @(posedge clk);
        acc_a <= sel ? ~a : a;
        acc_b <= sel ? a : ~a;
        store <= '{valid: 1'b1, op: op, acc_sel: sel, indirect: ind, addr: addr};
        @(posedge clk);
        store.valid <= 1'b0;
        #1;
    endtask : run_store

    task automatic chk_store(input logic rnd, input ars_acc_t a, input ars_word_t addr);
        ars_word_t e;
        e = exp_store(a, rnd, ctrl);
        run_store(rnd ? ARS_OP_ROUND : ARS_OP_TRUNC, a[0], 1'b0, addr, a);
        cmp_bit(xwr.valid, 1'b1, "xwr valid");
        cmp_word(xwr.addr, addr, "xwr addr");
        @(posedge clk);
        #1;
        cmp_word(mem_last.data, e, "store data");
        cmp_bit(xwr.valid, 1'b0, "xwr one cycle");
    endtask : chk_store

    task automatic test_reset();
        @(posedge clk);
        #1;
        cmp_word({14'h0000, ctrl_q}, 16'h0000, "ctrl reset");
        cmp_word(wbptr, 16'h0000, "pointer reset");
        cmp_bit(xwr.valid, 1'b0, "xwr reset");
        cmp_bit(shres.valid, 1'b0, "shift reset");
        $display("test reset done");
    endtask : test_reset

    task automatic test_trunc();
        set_ctrl(1'b1, 1'b0);
        chk_store(1'b0, 40'h12_3456_FFFF, 16'h0100);
        chk_store(1'b0, 40'h00_8000_0001, 16'h0102);
        chk_store(1'b1, 40'h01_0000_8000, 16'h0104);
        // Unknown store code must leave the X write bus idle
        run_store(ars_store_op_t'(3'h0), 1'b0, 1'b0, 16'h0110, 40'h00_1234_0000);
        cmp_bit(xwr.valid, 1'b0, "bad op no write");
        $display("test trunc done");
    endtask : test_trunc

    task automatic test_round();
        set_ctrl(1'b1, 1'b0);
        chk_store(1'b1, 40'h00_1234_8000, 16'h0200);
        chk_store(1'b1, 40'h00_1234_7FFF, 16'h0202);
        chk_store(1'b1, 40'hFF_FFFF_FFFF, 16'h0204);
        set_ctrl(1'b0, 1'b0);
        chk_store(1'b1, 40'h00_1234_8000, 16'h0206);
        chk_store(1'b1, 40'h00_1235_8000, 16'h0208);
        chk_store(1'b1, 40'h00_1234_8001, 16'h020A);
        chk_store(1'b1, 40'h00_1234_7FFF, 16'h020C);
        $display("test round done");
    endtask : test_round

    task automatic test_sat();
        set_ctrl(1'b1, 1'b1);
        chk_store(1'b0, 40'h00_8000_0000, 16'h0300);
        chk_store(1'b0, 40'h00_7FFF_FFFF, 16'h0302);
        chk_store(1'b1, 40'h00_7FFF_8000, 16'h0304);
        chk_store(1'b0, 40'hFF_7FFF_0000, 16'h0306);
        chk_store(1'b0, 40'hFF_8000_0000, 16'h0308);
        chk_store(1'b1, 40'h80_0000_0001, 16'h030A);
        chk_store(1'b1, 40'h7F_0000_0001, 16'h030C);
        $display("test sat done");
    endtask : test_sat

    task automatic test_macwb();
        set_ctrl(1'b1, 1'b0);
        @(posedge clk);
        wbptr_wr   <= 1'b1;
        wbptr_data <= 16'h1000;
        @(posedge clk);
        wbptr_wr <= 1'b0;
        run_store(ARS_OP_MACWB, 1'b1, 1'b1, 16'h0000, 40'h00_1234_8000);
        cmp_bit(xwr.valid, 1'b1, "wb valid");
        cmp_word(xwr.addr, 16'h1000, "wb addr");
        cmp_word(xwr.data, 16'h1235, "wb data");
        cmp_word(wbptr, 16'h1002, "wb post step");
        run_store(ARS_OP_MACWB, 1'b0, 1'b0, 16'h0000, 40'h00_2222_C000);
        cmp_bit(xwr.valid, 1'b0, "direct no write");
        cmp_word(wbptr, 16'h2223, "direct value");
        $display("test macwb done");
    endtask : test_macwb

    task automatic do_shift(input ars_src_t src, input logic arith, input logic [5:0] amt, input ars_word_t x);
        ars_shift_req_t r;
        ars_acc_t       e;
        r = '{valid: 1'b1, src: src, arith: arith, amount: amt, xdata: x};
        e = exp_shift(r, acc_a, acc_b);
        @(posedge clk);
        shift <= r;
        @(posedge clk);
        shift.valid <= 1'b0;
        #1;
        cmp_bit(shres.valid, 1'b1, "shift valid");
        cmp_acc(shres.acc, e, "shift acc");
        cmp_word(shres.word, amt[5] ? e[15:0] : e[31:16], "shift word");
    endtask : do_shift

    // Amounts stay within plus or minus 16
    task automatic test_shift();
        @(posedge clk);
        acc_a <= 40'h80_1234_5678;
        acc_b <= 40'h7F_00FF_F00D;
        #1;
        do_shift(ARS_SRC_A, 1'b1, 6'h10, 16'h0000);
        do_shift(ARS_SRC_A, 1'b0, 6'h01, 16'h0000);
        do_shift(ARS_SRC_B, 1'b0, 6'h30, 16'h0000);
        do_shift(ARS_SRC_B, 1'b1, 6'h00, 16'h0000);
        do_shift(ARS_SRC_X, 1'b1, 6'h04, 16'h8421);
        do_shift(ARS_SRC_X, 1'b0, 6'h04, 16'h8421);
        do_shift(ARS_SRC_X, 1'b0, 6'h3F, 16'hC001);
        $display("test shift done");
    endtask : test_shift

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    initial
    begin
        clk        = 1'b0;
        rstn       = 1'b0;
        acc_a      = '0;
        acc_b      = '0;
        ctrl_wr    = 1'b0;
        ctrl       = '0;
        wbptr_wr   = 1'b0;
        wbptr_data = '0;
        store      = '0;
        shift      = '0;
        errors     = 0;
        tests_run  = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        test_reset();
        test_trunc();
        test_round();
        test_sat();
        test_macwb();
        test_shift();
        complete_run();
    end

    // Tests need about 90 cycles; 2500 cycles (over twenty times that) before giving up
    initial
    begin
        #20000;
        errors = errors + 1;
        $display("mismatch t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule : ars_store_shift_test

`default_nettype wire
